/* dv/bridge_hdr_regs_test.sv */
// self-checking bench for the bridge header register bank and io window
`timescale 1ns/10ps
`default_nettype none
module bridge_hdr_regs_test;
  typedef struct packed { logic rd; logic err; logic [31:0] data; } apb_note_s; // expected apb answer
  logic        clock;        // 25 MHz clock
  logic        arst_n;       // async reset, active low
  logic        psel;         // apb select
  logic        penable;      // apb access phase
  logic        pwrite;       // apb direction
  logic [11:0] paddr;        // apb byte address
  logic [31:0] pwdata;       // apb write data
  logic [3:0]  pstrb;        // apb strobes
  logic [31:0] prdata;       // apb read data
  logic        pready;       // apb ready
  logic        pslverr;      // apb error
  logic        io_req;       // io decision request
  logic [31:0] io_addr;      // io address
  logic        io_fwd_valid; // decision pulse
  logic        io_fwd;       // forward decision
  apb_note_s   apb_notes[$]; // pending apb answers
  logic        io_notes[$];  // pending io decisions
  apb_note_s   mon_note;     // note taken by the monitor
  logic [7:0]  idx_tab[12];  // register indexes
  logic [31:0] mask_tab[12]; // writable bits per register
  logic [31:0] model[12];    // expected register contents
  logic        locked;       // capability lock mirror
  logic [7:0]  hits;         // expected forwarded count
  logic        last_hit;     // expected last decision
  int          err_count;    // mismatches
  int          checked;      // comparisons
  int          seed;         // random seed
  bridge_hdr_regs #(.ADDR_W(12)) uut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_req(io_req), .io_addr(io_addr), .io_fwd_valid(io_fwd_valid), .io_fwd(io_fwd));
  // clock generator
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // one comparison, reported at once
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // register contents after reset
  task automatic init_model;
    model = '{32'h0000_0000, 32'h0000_0000, {24'h00_0000, bridge_hdr_pkg::HDR_TYPE_VAL}, 32'h0000_0000,
              32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
              {24'h00_0000, bridge_hdr_pkg::RST_IO_BASE, 3'h0, bridge_hdr_pkg::RST_IO_CAP},
              {24'h00_0000, bridge_hdr_pkg::RST_IO_LIMIT, 3'h0, bridge_hdr_pkg::RST_IO_CAP}};
    locked = 1'b0;
    hits = 8'h00;
    last_hit = 1'b0;
  endtask : init_model
  function automatic logic [11:0] baddr(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : baddr
  // one apb transfer, expected answer noted first
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                          input logic [31:0] exp, input logic exp_err);
    apb_notes.push_back('{rd: ~wr, err: exp_err, data: exp});
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  // write through the table, model follows the access kinds
  task automatic write_reg(input int k, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] m;
    m = mask_tab[k];
    if (k == 10 && locked) m[0] = 1'b0;
    apb_xfer(1'b1, baddr(idx_tab[k]), wd, st, 32'h0000_0000, 1'b0);
    if (st[0]) model[k] = (model[k] & ~m) | (wd & m);
    model[11][0] = model[10][0];
  endtask : write_reg
  task automatic read_reg(input int k);
    apb_xfer(1'b0, baddr(idx_tab[k]), 32'h0000_0000, 4'h0, model[k], 1'b0);
  endtask : read_reg
  // io request, expected decision from the modelled window
  task automatic io_send(input logic [31:0] a);
    logic [15:0] lo;
    logic [15:0] hi;
    logic        h;
    lo = {model[10][7:4], 12'h000};
    hi = {model[11][7:4], 12'hFFF};
    h  = (a[31:16] === 16'h0000 && a[15:0] >= lo && a[15:0] <= hi);
    io_notes.push_back(h);
    if (h) hits = hits + 8'h01;
    last_hit = h;
    @(posedge clock);
    io_req  <= 1'b1;
    io_addr <= a;
  endtask : io_send
  // set a window, then probe its edges back to back
  task automatic io_window(input logic [3:0] b, input logic [3:0] l);
    write_reg(10, {24'h00_0000, b, 3'h0, model[10][0]}, 4'h1);
    write_reg(11, {24'h00_0000, l, 4'h0}, 4'h1);
    io_send({16'h0000, b, 12'h000});
    io_send({16'h0000, b, 12'h000} - 32'h0000_0001);
    io_send({16'h0000, l, 12'hFFF});
    io_send({16'h0000, l, 12'hFFF} + 32'h0000_0001);
    io_send({16'h0001, b, 12'h000});
    io_send($random(seed) & 32'h0000_FFFF);
    @(posedge clock);
    io_req <= 1'b0;
  endtask : io_window
  // monitor: each result takes the oldest note
  always @(posedge clock) begin
    if (arst_n === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (apb_notes.size() == 0) check("apb note", 32'h0000_0001, 32'h0000_0000);
      else begin
        mon_note = apb_notes.pop_front();
        check("pslverr", {31'h0, mon_note.err}, {31'h0, pslverr});
        if (mon_note.rd) check("prdata", mon_note.data, prdata);
      end
    end
    if (io_fwd_valid === 1'b1) begin
      if (io_notes.size() == 0) check("io note", 32'h0000_0001, 32'h0000_0000);
      else check("io_fwd", {31'h0, io_notes.pop_front()}, {31'h0, io_fwd});
    end
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    seed = 76;
    {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb, io_req, io_addr} = '0;
    err_count = 0;
    checked = 0;
    idx_tab = '{bridge_hdr_pkg::IDX_CACHE_LINE, bridge_hdr_pkg::IDX_UP_LAT, bridge_hdr_pkg::IDX_HDR_TYPE,
                bridge_hdr_pkg::IDX_SELF_TEST, bridge_hdr_pkg::IDX_BASE_ZERO, bridge_hdr_pkg::IDX_BASE_ONE,
                bridge_hdr_pkg::IDX_UP_BUS, bridge_hdr_pkg::IDX_DOWN_BUS, bridge_hdr_pkg::IDX_HIGH_BUS,
                bridge_hdr_pkg::IDX_DOWN_LAT, bridge_hdr_pkg::IDX_IO_BASE, bridge_hdr_pkg::IDX_IO_LIMIT};
    mask_tab = '{32'h0000_00FF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                 32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_0000, 32'h0000_00F1, 32'h0000_00F0};
    init_model;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    for (int k = 0; k < 12; k++) read_reg(k);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 12; k++) write_reg(k, $random(seed), 4'h1);
      for (int k = 0; k < 12; k++) read_reg(k);
    end
    write_reg(0, $random(seed), 4'hE);
    read_reg(0);
    apb_xfer(1'b0, 12'h3FC, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'b1);
    apb_xfer(1'b0, 12'h031, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'b1);
    apb_xfer(1'b1, baddr(8'h11), $random(seed), 4'hF, 32'h0000_0000, 1'b1);
    apb_xfer(1'b1, baddr(bridge_hdr_pkg::IDX_LOCK_CTRL), 32'h0000_0001, 4'h1, 32'h0000_0000, 1'b0);
    locked = 1'b1;
    apb_xfer(1'b0, baddr(bridge_hdr_pkg::IDX_LOCK_CTRL), 32'h0000_0000, 4'h0, 32'h0000_0001, 1'b0);
    write_reg(10, ~model[10], 4'h1);
    read_reg(10);
    read_reg(11);
    apb_xfer(1'b1, baddr(bridge_hdr_pkg::IDX_LOCK_CTRL), 32'h0000_0000, 4'h1, 32'h0000_0000, 1'b0);
    locked = 1'b0;
    io_window(4'h2, 4'h5);
    io_window(4'h7, 4'h7);
    io_window(4'h6, 4'h3);
    io_window(4'h0, 4'hF);
    apb_xfer(1'b0, baddr(bridge_hdr_pkg::IDX_FWD_STATUS), 32'h0, 4'h0, {16'h0, hits, 7'h0, last_hit}, 1'b0);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    init_model;
    for (int k = 0; k < 12; k++) read_reg(k);
    apb_xfer(1'b0, baddr(bridge_hdr_pkg::IDX_FWD_STATUS), 32'h0, 4'h0, {16'h0, hits, 7'h0, last_hit}, 1'b0);
    repeat (4) @(posedge clock);
    check("pending notes", 32'h0000_0000, apb_notes.size() + io_notes.size());
    tally_and_finish;
  end
endmodule : bridge_hdr_regs_test
`default_nettype wire

/* inc/bridge_hdr_pkg.sv */
// constants for the bridge header register bank and io window
package bridge_hdr_pkg;
  // register indexes; byte address is index times four
  localparam logic [7:0]  IDX_CACHE_LINE  = 8'h0C; // cache_line_size
  localparam logic [7:0]  IDX_UP_LAT      = 8'h0D; // upstream_latency_timer
  localparam logic [7:0]  IDX_HDR_TYPE    = 8'h0E; // header_layout_type
  localparam logic [7:0]  IDX_SELF_TEST   = 8'h0F; // self_test_control
  localparam logic [7:0]  IDX_BASE_ZERO   = 8'h10; // base_address_zero
  localparam logic [7:0]  IDX_BASE_ONE    = 8'h14; // base_address_one
  localparam logic [7:0]  IDX_UP_BUS      = 8'h18; // upstream_bus_number
  localparam logic [7:0]  IDX_DOWN_BUS    = 8'h19; // downstream_bus_number
  localparam logic [7:0]  IDX_HIGH_BUS    = 8'h1A; // highest_downstream_bus_number
  localparam logic [7:0]  IDX_DOWN_LAT    = 8'h1B; // downstream_latency_timer
  localparam logic [7:0]  IDX_IO_BASE     = 8'h1C; // io_window_lower_bound
  localparam logic [7:0]  IDX_IO_LIMIT    = 8'h1D; // io_window_upper_bound
  localparam logic [7:0]  IDX_FWD_STATUS  = 8'h20; // forwarding status
  localparam logic [7:0]  IDX_LOCK_CTRL   = 8'h21; // capability lock
  // reset and fixed values
  localparam logic [7:0]  RST_BYTE        = 8'h00; // writable bytes reset
  localparam logic        RST_IO_CAP      = 1'b1;  // 32-bit io addressing
  localparam logic [3:0]  RST_IO_BASE     = 4'hF;  // window base nibble
  localparam logic [3:0]  RST_IO_LIMIT    = 4'h0;  // window limit nibble
  localparam logic [7:0]  HDR_TYPE_VAL    = 8'h01; // type 1, single function
  localparam logic [31:0] RO_ZERO         = 32'h0000_0000; // fixed zero fields
  // field positions
  localparam int          CAP_BIT         = 0;     // capability bit
  localparam int          WIN_LSB         = 4;     // window nibble low bit
  localparam int          WIN_MSB         = 7;     // window nibble high bit
  localparam int          LOCK_BIT        = 0;     // lock control bit
  localparam int          STAT_HIT_BIT    = 0;     // last decision bit
  localparam int          STAT_CNT_LSB    = 8;     // hit counter low bit
  localparam int          STAT_CNT_MSB    = 15;    // hit counter high bit
  // window address fill below the 4 KB nibble
  localparam logic [11:0] WIN_LOW_FILL    = 12'h000; // base low bits
  localparam logic [11:0] WIN_HIGH_FILL   = 12'hFFF; // limit low bits
  localparam logic [15:0] IO_UPPER_ZERO   = 16'h0000; // upper io address
endpackage : bridge_hdr_pkg

/* logic/apb_cfg_port.sv */
// apb slave decode: phases, word index and unmapped address check
`timescale 1ns/10ps
`default_nettype none
module apb_cfg_port #(
  parameter int ADDR_W = 12               // apb address width
) (
  input  wire logic [ADDR_W-1:0] paddr,   // byte address
  input  wire logic              psel,    // slave select
  input  wire logic              penable, // access phase
  input  wire logic              pwrite,  // write direction
  input  wire logic [3:0]        pstrb,   // byte lane strobes
  output logic [7:0]             reg_idx, // word index
  output logic                   rd_setup,// read setup cycle
  output logic                   wr_en,   // write taking effect
  output logic                   pready,  // always ready
  output logic                   pslverr  // unmapped access
);
  logic mapped; // index names a register

  // decode address into an index and check it names a register
  always_comb begin
    reg_idx = paddr[9:2];
    case (reg_idx)
      bridge_hdr_pkg::IDX_CACHE_LINE, bridge_hdr_pkg::IDX_UP_LAT,
      bridge_hdr_pkg::IDX_HDR_TYPE,   bridge_hdr_pkg::IDX_SELF_TEST,
      bridge_hdr_pkg::IDX_BASE_ZERO,  bridge_hdr_pkg::IDX_BASE_ONE,
      bridge_hdr_pkg::IDX_UP_BUS,     bridge_hdr_pkg::IDX_DOWN_BUS,
      bridge_hdr_pkg::IDX_HIGH_BUS,   bridge_hdr_pkg::IDX_DOWN_LAT,
      bridge_hdr_pkg::IDX_IO_BASE,    bridge_hdr_pkg::IDX_IO_LIMIT,
      bridge_hdr_pkg::IDX_FWD_STATUS, bridge_hdr_pkg::IDX_LOCK_CTRL: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    // misaligned or high address bits set: not mapped
    if (paddr[1:0] != 2'b00 || paddr[ADDR_W-1:10] != '0) begin
      mapped  = 1'b0;
      reg_idx = '1; // names no register, so a read gives zero
    end
    pready   = 1'b1;
    pslverr  = psel & penable & ~mapped;
    rd_setup = psel & ~penable & ~pwrite;
    // only lane zero carries data; unmapped writes are dropped
    wr_en    = psel & penable & pwrite & mapped & pstrb[0];
  end
endmodule : apb_cfg_port
`default_nettype wire

/* logic/bridge_hdr_regs.sv */
// bridge header words 0x0C to 0x1D with the io forwarding window
`timescale 1ns/10ps
`default_nettype none
module bridge_hdr_regs #(
  parameter int ADDR_W = 12                 // apb address width
) (
  input  wire logic              clock,     // 25 MHz config clock
  input  wire logic              arst_n,    // async reset, active low
  input  wire logic              psel,      // apb select
  input  wire logic              penable,   // apb access phase
  input  wire logic              pwrite,    // apb write
  input  wire logic [ADDR_W-1:0] paddr,     // apb byte address
  input  wire logic [31:0]       pwdata,    // apb write data
  input  wire logic [3:0]        pstrb,     // apb byte strobes
  output logic [31:0]            prdata,    // apb read data
  output logic                   pready,    // apb ready
  output logic                   pslverr,   // apb error, unmapped
  input  wire logic              io_req,    // io transaction to decide
  input  wire logic [31:0]       io_addr,   // io transaction address
  output logic                   io_fwd_valid, // decision pulse
  output logic                   io_fwd    // forward across bridge
);

  // all state of the bank
  typedef struct packed {
    logic [7:0]  cache_line; // scratch byte
    logic [7:0]  up_bus;     // upstream bus number
    logic [7:0]  down_bus;   // downstream bus number
    logic [7:0]  high_bus;   // highest downstream bus
    logic        io_cap;     // io addressing capability
    logic [3:0]  io_base;    // window base nibble
    logic [3:0]  io_limit;   // window limit nibble
    logic        lock;       // capability bit locked
    logic [31:0] rdata;      // read data held for access phase
    logic        fwd_valid;  // decision pulse
    logic        fwd;        // decision result
    logic [7:0]  hit_cnt;    // forwarded transactions, wraps
  } regs_s;

  regs_s       st_q;      // registered state
  regs_s       st_d;      // next state
  logic [7:0]  reg_idx;   // word index of current access
  logic        rd_setup;  // read setup cycle
  logic        wr_en;     // write takes effect this edge
  logic        in_window; // io address inside window
  logic [31:0] rd_mux;    // value of addressed register
  logic [7:0]  wbyte;     // low write byte

  // bus decode and phase strobes
  apb_cfg_port #(
    .ADDR_W   (ADDR_W)
  ) u_port (
    .paddr    (paddr),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pstrb    (pstrb),
    .reg_idx  (reg_idx),
    .rd_setup (rd_setup),
    .wr_en    (wr_en),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  // window compare on the live base and limit
  io_window_match u_match (
    .win_base  (st_q.io_base),
    .win_limit (st_q.io_limit),
    .io_addr   (io_addr),
    .in_window (in_window)
  );

  // read value of each register; unmapped words read zero
  always_comb begin
    rd_mux = bridge_hdr_pkg::RO_ZERO;
    case (reg_idx)
      bridge_hdr_pkg::IDX_CACHE_LINE: begin
        rd_mux[7:0] = st_q.cache_line;
      end
      bridge_hdr_pkg::IDX_UP_LAT: begin
        rd_mux = bridge_hdr_pkg::RO_ZERO;
      end
      bridge_hdr_pkg::IDX_HDR_TYPE: begin
        rd_mux[7:0] = bridge_hdr_pkg::HDR_TYPE_VAL;
      end
      bridge_hdr_pkg::IDX_SELF_TEST: begin
        rd_mux = bridge_hdr_pkg::RO_ZERO;
      end
      bridge_hdr_pkg::IDX_BASE_ZERO, bridge_hdr_pkg::IDX_BASE_ONE: begin
        rd_mux = bridge_hdr_pkg::RO_ZERO;
      end
      bridge_hdr_pkg::IDX_UP_BUS: begin
        rd_mux[7:0] = st_q.up_bus;
      end
      bridge_hdr_pkg::IDX_DOWN_BUS: begin
        rd_mux[7:0] = st_q.down_bus;
      end
      bridge_hdr_pkg::IDX_HIGH_BUS: begin
        rd_mux[7:0] = st_q.high_bus;
      end
      bridge_hdr_pkg::IDX_DOWN_LAT: begin
        rd_mux = bridge_hdr_pkg::RO_ZERO;
      end
      bridge_hdr_pkg::IDX_IO_BASE: begin
        // reserved bits 3:1 stay zero
        rd_mux[bridge_hdr_pkg::CAP_BIT] = st_q.io_cap;
        rd_mux[bridge_hdr_pkg::WIN_MSB:bridge_hdr_pkg::WIN_LSB] = st_q.io_base;
      end
      bridge_hdr_pkg::IDX_IO_LIMIT: begin
        rd_mux[bridge_hdr_pkg::CAP_BIT] = st_q.io_cap;
        rd_mux[bridge_hdr_pkg::WIN_MSB:bridge_hdr_pkg::WIN_LSB] = st_q.io_limit;
      end
      bridge_hdr_pkg::IDX_FWD_STATUS: begin
        rd_mux[bridge_hdr_pkg::STAT_HIT_BIT] = st_q.fwd;
        rd_mux[bridge_hdr_pkg::STAT_CNT_MSB:bridge_hdr_pkg::STAT_CNT_LSB] = st_q.hit_cnt;
      end
      bridge_hdr_pkg::IDX_LOCK_CTRL: begin
        rd_mux[bridge_hdr_pkg::LOCK_BIT] = st_q.lock;
      end
      default: begin
        rd_mux = bridge_hdr_pkg::RO_ZERO;
      end
    endcase
  end

  // next state: writes, read capture, forwarding decision
  always_comb begin
    st_d  = st_q;
    wbyte = pwdata[7:0];
    // read data is caught in the setup cycle and held
    if (rd_setup) begin
      st_d.rdata = rd_mux;
    end
    // writes; fixed fields have no storage so writes vanish
    if (wr_en) begin
      case (reg_idx)
        bridge_hdr_pkg::IDX_CACHE_LINE: begin
          st_d.cache_line = wbyte;
        end
        bridge_hdr_pkg::IDX_UP_BUS: begin
          st_d.up_bus = wbyte;
        end
        bridge_hdr_pkg::IDX_DOWN_BUS: begin
          st_d.down_bus = wbyte;
        end
        bridge_hdr_pkg::IDX_HIGH_BUS: begin
          st_d.high_bus = wbyte;
        end
        bridge_hdr_pkg::IDX_IO_BASE: begin
          // capability bit only moves while unlocked
          if (!st_q.lock) begin
            st_d.io_cap = wbyte[bridge_hdr_pkg::CAP_BIT];
          end
          st_d.io_base = wbyte[bridge_hdr_pkg::WIN_MSB:bridge_hdr_pkg::WIN_LSB];
        end
        bridge_hdr_pkg::IDX_IO_LIMIT: begin
          // bit 0 is a mirror, bits 3:1 reserved
          st_d.io_limit = wbyte[bridge_hdr_pkg::WIN_MSB:bridge_hdr_pkg::WIN_LSB];
        end
        bridge_hdr_pkg::IDX_LOCK_CTRL: begin
          st_d.lock = wbyte[bridge_hdr_pkg::LOCK_BIT];
        end
        default: begin
          st_d.lock = st_q.lock; // read-only words
        end
      endcase
    end
    // one decision per io request, registered
    st_d.fwd_valid = io_req;
    if (io_req) begin
      st_d.fwd = in_window;
      if (in_window) begin
        st_d.hit_cnt = st_q.hit_cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q.cache_line <= bridge_hdr_pkg::RST_BYTE;
      st_q.up_bus     <= bridge_hdr_pkg::RST_BYTE;
      st_q.down_bus   <= bridge_hdr_pkg::RST_BYTE;
      st_q.high_bus   <= bridge_hdr_pkg::RST_BYTE;
      st_q.io_cap     <= bridge_hdr_pkg::RST_IO_CAP;
      st_q.io_base    <= bridge_hdr_pkg::RST_IO_BASE;
      st_q.io_limit   <= bridge_hdr_pkg::RST_IO_LIMIT;
      st_q.lock       <= 1'b0;
      st_q.rdata      <= bridge_hdr_pkg::RO_ZERO;
      st_q.fwd_valid  <= 1'b0;
      st_q.fwd        <= 1'b0;
      st_q.hit_cnt    <= bridge_hdr_pkg::RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata       = st_q.rdata;
  assign io_fwd_valid = st_q.fwd_valid;
  assign io_fwd       = st_q.fwd;

  // checks
  logic rd_acc; // read access phase
  assign rd_acc = psel & penable & ~pwrite;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_cls_rw;
    (wr_en && reg_idx == bridge_hdr_pkg::IDX_CACHE_LINE) |=> (st_q.cache_line == $past(pwdata[7:0]));
  endproperty
  a_cls_rw: assert property (p_cls_rw) else $error("cache line size write lost");

  property p_up_lat_zero;
    (rd_acc && reg_idx == bridge_hdr_pkg::IDX_UP_LAT) |-> (prdata == bridge_hdr_pkg::RO_ZERO);
  endproperty
  a_up_lat_zero: assert property (p_up_lat_zero) else $error("upstream latency not zero");

  property p_hdr_type;
    (rd_acc && reg_idx == bridge_hdr_pkg::IDX_HDR_TYPE) |-> (prdata[7:0] == bridge_hdr_pkg::HDR_TYPE_VAL);
  endproperty
  a_hdr_type: assert property (p_hdr_type) else $error("header type wrong");

  property p_self_test;
    (rd_acc && reg_idx == bridge_hdr_pkg::IDX_SELF_TEST) |-> (prdata == bridge_hdr_pkg::RO_ZERO);
  endproperty
  a_self_test: assert property (p_self_test) else $error("self test not zero");

  property p_bars_zero;
    (rd_acc && (reg_idx == bridge_hdr_pkg::IDX_BASE_ZERO || reg_idx == bridge_hdr_pkg::IDX_BASE_ONE))
      |-> (prdata == bridge_hdr_pkg::RO_ZERO);
  endproperty
  a_bars_zero: assert property (p_bars_zero) else $error("base address not zero");

  property p_bus_rw;
    (rd_acc && reg_idx == bridge_hdr_pkg::IDX_UP_BUS) |-> (prdata[7:0] == st_q.up_bus);
  endproperty
  a_bus_rw: assert property (p_bus_rw) else $error("upstream bus readback wrong");

  property p_down_bus;
    (wr_en && reg_idx == bridge_hdr_pkg::IDX_DOWN_BUS) |=> (st_q.down_bus == $past(pwdata[7:0]));
  endproperty
  a_down_bus: assert property (p_down_bus) else $error("downstream bus write lost");

  property p_high_bus;
    (wr_en && reg_idx == bridge_hdr_pkg::IDX_HIGH_BUS) |=> (st_q.high_bus == $past(pwdata[7:0]));
  endproperty
  a_high_bus: assert property (p_high_bus) else $error("highest bus write lost");

  property p_down_lat_zero;
    (rd_acc && reg_idx == bridge_hdr_pkg::IDX_DOWN_LAT) |-> (prdata == bridge_hdr_pkg::RO_ZERO);
  endproperty
  a_down_lat_zero: assert property (p_down_lat_zero) else $error("downstream latency not zero");

  property p_cap_lock;
    (wr_en && reg_idx == bridge_hdr_pkg::IDX_IO_BASE && st_q.lock) |=> $stable(st_q.io_cap);
  endproperty
  a_cap_lock: assert property (p_cap_lock) else $error("locked capability changed");

  property p_cap_mirror;
    (rd_acc && reg_idx == bridge_hdr_pkg::IDX_IO_LIMIT) |-> (prdata[bridge_hdr_pkg::CAP_BIT] == st_q.io_cap);
  endproperty
  a_cap_mirror: assert property (p_cap_mirror) else $error("limit bit zero not mirrored");

  property p_base_nib;
    (wr_en && reg_idx == bridge_hdr_pkg::IDX_IO_BASE) |=> (st_q.io_base == $past(pwdata[7:4]));
  endproperty
  a_base_nib: assert property (p_base_nib) else $error("io base write lost");

  property p_limit_nib;
    (wr_en && reg_idx == bridge_hdr_pkg::IDX_IO_LIMIT) |=> (st_q.io_limit == $past(pwdata[7:4]));
  endproperty
  a_limit_nib: assert property (p_limit_nib) else $error("io limit write lost");

  property p_fwd_hit;
    (io_req && io_addr[31:16] == bridge_hdr_pkg::IO_UPPER_ZERO &&
     io_addr[15:12] >= st_q.io_base && io_addr[15:12] <= st_q.io_limit) |=> (io_fwd_valid && io_fwd);
  endproperty
  a_fwd_hit: assert property (p_fwd_hit) else $error("in-window io not forwarded");

  property p_resv_zero;
    (rd_acc && (reg_idx == bridge_hdr_pkg::IDX_IO_BASE || reg_idx == bridge_hdr_pkg::IDX_IO_LIMIT))
      |-> (prdata[3:1] == 3'b000 && prdata[31:8] == 24'h00_0000);
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

  property p_empty_win;
    (io_req && st_q.io_limit < st_q.io_base) |=> (io_fwd_valid && !io_fwd);
  endproperty
  a_empty_win: assert property (p_empty_win) else $error("empty window forwarded");

endmodule : bridge_hdr_regs
`default_nettype wire

/* logic/io_window_match.sv */
// inclusive io window compare against base and limit
`timescale 1ns/10ps
`default_nettype none
module io_window_match (
  input  wire logic [3:0]  win_base,  // base nibble, address bits 15:12
  input  wire logic [3:0]  win_limit, // limit nibble, address bits 15:12
  input  wire logic [31:0] io_addr,   // transaction address
  output logic             in_window  // address falls inside window
);
  logic [15:0] low_bound;  // lowest address of window
  logic [15:0] high_bound; // highest address of window

  // limit takes the low twelve bits as all ones, base as all zeros
  always_comb begin
    low_bound  = {win_base, bridge_hdr_pkg::WIN_LOW_FILL};
    high_bound = {win_limit, bridge_hdr_pkg::WIN_HIGH_FILL};
    // both ends inclusive; limit below base leaves nothing inside
    in_window  = (io_addr[31:16] == bridge_hdr_pkg::IO_UPPER_ZERO) &&
                 (io_addr[15:0] >= low_bound) &&
                 (io_addr[15:0] <= high_bound);
  end
endmodule : io_window_match
`default_nettype wire
